// ==== design/touch_status.sv ====
// How it works
// - panel drivers switched on: wait the settle time, then start sampling
// - settle codes 000..110 give 0/100us/500us/1ms/5ms/10ms/100ms, 111 also 100ms; reset 000
// - filter bit 0 selects mean, 1 selects median; resets to 0
// - pin function 00: pin low while a touch is seen
// - pin function 01: pin low from set done until results read
// - pin function 1x: low on touch, high when conversions finish
// - pin function sits in status bits 15:14, read/write, resets to 10
// - read-only off flag is 1 while converter is powered down
// - read-only source flag is 1 when device sequences on its own
// - ready flag sets on set done, clears once all results read
// - horizontal new flag sets on store, clears after it is read
// - vertical new flag sets on store, clears after it is read
// - first pressure new flag sets on store, clears after it is read
// - continuous scan repeats until pen lifted or stop command
`timescale 1ns/100ps
`default_nettype none
module touch_status
	import touch_status_pkg::*;
#(
	parameter int CYC_100US_P = CYC_100US,
	parameter int CYC_500US_P = CYC_500US,
	parameter int CYC_1MS_P = CYC_1MS,
	parameter int CYC_5MS_P = CYC_5MS,
	parameter int CYC_10MS_P = CYC_10MS,
	parameter int CYC_100MS_P = CYC_100MS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	input wire logic penTouch,
	input wire logic driversOn,
	input wire logic convActive,
	input wire logic selfControlled,
	input wire logic setDone,
	input wire logic xStored,
	input wire logic yStored,
	input wire logic z1Stored,
	input wire logic xReadDone,
	input wire logic yReadDone,
	input wire logic z1ReadDone,
	input wire logic otherPending,
	input wire logic stopCmd,
	output logic sampleStart,
	output logic filterMedian,
	output logic scanRepeat,
	output logic touchReadyPinN
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] ctrl;
		logic [1:0] pinFn;
		logic offFlag;
		logic selfFlag;
		logic ready;
		logic xNew;
		logic yNew;
		logic z1New;
		logic penS1;
		logic penS2;
		logic penS3;
		logic pen;
		logic penPending;
		logic scanActive;
		logic driversPrev;
		settle_state_t st;
		logic [SETTLE_W-1:0] cnt;
		logic sampleStart;
		logic filterMedian;
		logic scanRepeat;
		logic pinN;
		logic [15:0] rdata;
	} state_t;

	state_t s;
	state_t next_s;
	logic [SETTLE_W-1:0] settleCyc;
	logic [2:0] settleCode;

	if (CYC_100MS_P >= (1 << SETTLE_W) || CYC_100US_P < 1) begin : g_chk
		$error("settle counts do not fit the counter");
	end

	assign settleCode = s.ctrl[CTRL_SETTLE_LSB +: 3];

	always_comb begin
		case (settleCode)
		3'h0: settleCyc = '0;
		3'h1: settleCyc = SETTLE_W'(CYC_100US_P);
		3'h2: settleCyc = SETTLE_W'(CYC_500US_P);
		3'h3: settleCyc = SETTLE_W'(CYC_1MS_P);
		3'h4: settleCyc = SETTLE_W'(CYC_5MS_P);
		3'h5: settleCyc = SETTLE_W'(CYC_10MS_P);
		// never shorten settling on the spare code
		default: settleCyc = SETTLE_W'(CYC_100MS_P);
		endcase
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.sampleStart = 1'b0;
		// pen pin comes from outside: three stages, agree on last two
		next_s.penS1 = penTouch;
		next_s.penS2 = s.penS1;
		next_s.penS3 = s.penS2;
		if (s.penS2 == s.penS3) begin
			next_s.pen = s.penS3;
		end
		next_s.offFlag = !convActive;
		next_s.selfFlag = selfControlled;
		next_s.driversPrev = driversOn;

		if (regWrite && regAddr == CTRL_ADDR) begin
			next_s.ctrl = regWdata;
			if (regWdata[CTRL_SCAN_LSB +: 4] == SCAN_XY
				|| regWdata[CTRL_SCAN_LSB +: 4] == SCAN_XYZ) begin
				next_s.scanActive = 1'b1;
			end else begin
				next_s.scanActive = 1'b0;
			end
		end
		if (regWrite && regAddr == STATUS_ADDR) begin
			next_s.pinFn = regWdata[STAT_PINFN_LSB +: 2];
		end
		if (stopCmd || (s.scanActive && !s.pen)) begin
			next_s.scanActive = 1'b0;
		end

		case (s.st)
		SETTLE_IDLE: begin
			if (driversOn && !s.driversPrev) begin
				if (settleCyc == '0) begin
					next_s.sampleStart = 1'b1;
				end else begin
					next_s.cnt = settleCyc - 1'b1;
					next_s.st = SETTLE_WAIT;
				end
			end
		end
		SETTLE_WAIT: begin
			if (!driversOn) begin
				next_s.st = SETTLE_IDLE;
			end else if (s.cnt == '0) begin
				next_s.sampleStart = 1'b1;
				next_s.st = SETTLE_IDLE;
			end else begin
				next_s.cnt = s.cnt - 1'b1;
			end
		end
		default: next_s.st = SETTLE_IDLE;
		endcase

		// clears first, so a store in the same cycle wins
		if (xReadDone) next_s.xNew = 1'b0;
		if (yReadDone) next_s.yNew = 1'b0;
		if (z1ReadDone) next_s.z1New = 1'b0;
		if (xStored) next_s.xNew = 1'b1;
		if (yStored) next_s.yNew = 1'b1;
		if (z1Stored) next_s.z1New = 1'b1;
		if ((xReadDone || yReadDone || z1ReadDone) && !next_s.xNew
			&& !next_s.yNew && !next_s.z1New && !otherPending) begin
			next_s.ready = 1'b0;
		end
		if (setDone) next_s.ready = 1'b1;

		if (setDone) next_s.penPending = 1'b0;
		if (s.pen && !s.penS3 == 1'b0 && !s.penPending && s.pen) begin
			next_s.penPending = next_s.penPending;
		end
		if (next_s.pen && !s.pen) next_s.penPending = 1'b1;

		case (s.pinFn)
		PINFN_PEN: next_s.pinN = !s.pen;
		PINFN_DATA: next_s.pinN = !s.ready;
		default: next_s.pinN = !s.penPending;
		endcase

		next_s.filterMedian = s.ctrl[CTRL_FILTER_BIT];
		next_s.scanRepeat = s.scanActive && s.pen;

		if (regRead) begin
			if (regAddr == CTRL_ADDR) begin
				next_s.rdata = s.ctrl;
			end else if (regAddr == STATUS_ADDR) begin
				next_s.rdata = {s.pinFn, s.offFlag, s.selfFlag, s.ready,
					s.xNew, s.yNew, s.z1New, 8'h00};
			end else begin
				next_s.rdata = 16'h0000;
			end
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.pinFn <= PINFN_RESET;
			s.st <= SETTLE_IDLE;
			s.pinN <= 1'b1;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign regRdata = s.rdata;
	assign sampleStart = s.sampleStart;
	assign filterMedian = s.filterMedian;
	assign scanRepeat = s.scanRepeat;
	assign touchReadyPinN = s.pinN;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence q_rise_zero;
		ce && s.st == SETTLE_IDLE && driversOn && !s.driversPrev
			&& settleCode == 3'h0;
	endsequence
	sequence q_wait_long;
		ce && s.st == SETTLE_WAIT && s.cnt > 1 && driversOn;
	endsequence

	property p_settle_zero;
		q_rise_zero |=> sampleStart;
	endproperty
	a_settle_zero: assert property (p_settle_zero)
		else $error("zero settle did not start at once");

	property p_no_early;
		q_wait_long ##1 ce |=> !sampleStart;
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("sample started before settling");

	property p_filter;
		ce && regWrite && regAddr == CTRL_ADDR ##1 ce
			|=> filterMedian == $past(regWdata[CTRL_FILTER_BIT], 2);
	endproperty
	a_filter: assert property (p_filter)
		else $error("filter select not applied");

	property p_pin_pen;
		ce && s.pinFn == PINFN_PEN && s.pen |=> !touchReadyPinN;
	endproperty
	a_pin_pen: assert property (p_pin_pen)
		else $error("pen mode pin not low");

	property p_pin_data;
		ce && s.pinFn == PINFN_DATA |=> touchReadyPinN == !$past(s.ready);
	endproperty
	a_pin_data: assert property (p_pin_data)
		else $error("data mode pin wrong");

	property p_pin_both;
		ce && s.pinFn[1] && setDone && s.pen && $past(s.pen) ##1 ce
			|=> touchReadyPinN;
	endproperty
	a_pin_both: assert property (p_pin_both)
		else $error("pin not released after conversions");

	property p_pinfn_rw;
		ce && regWrite && regAddr == STATUS_ADDR
			|=> s.pinFn == $past(regWdata[15:14]);
	endproperty
	a_pinfn_rw: assert property (p_pinfn_rw)
		else $error("pin function not written");

	property p_ready_set;
		ce && setDone |=> s.ready;
	endproperty
	a_ready_set: assert property (p_ready_set)
		else $error("ready flag not set");

	property p_store_wins;
		ce && xStored && xReadDone |=> s.xNew;
	endproperty
	a_store_wins: assert property (p_store_wins)
		else $error("store lost against clear");

	property p_x_clear;
		ce && xReadDone && !xStored |=> !s.xNew;
	endproperty
	a_x_clear: assert property (p_x_clear)
		else $error("horizontal flag not cleared");

	property p_scan_stop;
		ce && s.scanActive && (stopCmd || !s.pen) && !regWrite
			|=> !s.scanActive;
	endproperty
	a_scan_stop: assert property (p_scan_stop)
		else $error("scan did not stop");

endmodule
`default_nettype wire

// ==== design/touch_status_pkg.sv ====
package touch_status_pkg;

	// ------------------------------------------------------------------
	// register map and field layout
	// ------------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam logic [6:0] CTRL_ADDR = 7'h00;
	localparam logic [6:0] STATUS_ADDR = 7'h01;
	localparam int CTRL_FILTER_BIT = 0;
	localparam int CTRL_SETTLE_LSB = 1;
	localparam int CTRL_SCAN_LSB = 10;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [3:0] SCAN_XY = 4'h1;
	localparam logic [3:0] SCAN_XYZ = 4'h2;
	localparam int STAT_PINFN_LSB = 14;
	localparam int STAT_OFF_BIT = 13;
	localparam int STAT_SELF_BIT = 12;
	localparam int STAT_READY_BIT = 11;
	localparam int STAT_HORIZ_BIT = 10;
	localparam int STAT_VERT_BIT = 9;
	localparam int STAT_PRESS1_BIT = 8;
	localparam logic [1:0] PINFN_RESET = 2'h2;
	localparam logic [1:0] PINFN_PEN = 2'h0;
	localparam logic [1:0] PINFN_DATA = 2'h1;

	// ------------------------------------------------------------------
	// settling times, as printed, and cycle counts at clk_sys
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_100_US = 100;
	localparam int SETTLE_500_US = 500;
	localparam int SETTLE_1_MS = 1;
	localparam int SETTLE_5_MS = 5;
	localparam int SETTLE_10_MS = 10;
	localparam int SETTLE_100_MS = 100;
	localparam int CYC_100US = (SETTLE_100_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CYC_500US = (SETTLE_500_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CYC_1MS = (SETTLE_1_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CYC_5MS = (SETTLE_5_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CYC_10MS = (SETTLE_10_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CYC_100MS = (SETTLE_100_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SETTLE_W = 23;

	typedef enum logic {SETTLE_IDLE, SETTLE_WAIT} settle_state_t;

endpackage

// ==== verif/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model
	import touch_status_pkg::*;
(
	input wire logic clk_sys,
	output logic regWrite,
	output logic regRead,
	output logic [ADDR_W-1:0] regAddr,
	output logic [15:0] regWdata,
	input wire logic [15:0] regRdata
);
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 7'h00;
		regWdata = 16'h0000;
	end
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		// released data shows no stale word
		regWdata <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask
endmodule
`default_nettype wire

// ==== verif/touch_adc_status_and_settling_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module touch_adc_status_and_settling_test
	import touch_status_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic driversOn = 1'b0;
	logic penTouch = 1'b0;
	logic convActive = 1'b1;
	logic selfControlled = 1'b0;
	logic otherPending = 1'b0;
	// stopCmd z1Rd yRd xRd z1St ySt xSt setDone
	logic [7:0] pl = 8'h00;
	logic regWrite, regRead, sampleStart, filterMedian;
	logic scanRepeat, touchReadyPinN;
	logic [ADDR_W-1:0] regAddr;
	logic [15:0] regWdata, regRdata, v;
	logic [1:0] ob;
	int num_errors = 0;
	int cmp_count = 0;
	assign ob = {scanRepeat, touchReadyPinN};
	always #10 clk_sys = ~clk_sys;

	// short settle counts keep the run brief
	touch_status #(.CYC_100US_P(4), .CYC_500US_P(8), .CYC_1MS_P(12),
		.CYC_5MS_P(16), .CYC_10MS_P(20), .CYC_100MS_P(40)) i_dut (
		.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .penTouch(penTouch),
		.driversOn(driversOn), .convActive(convActive),
		.selfControlled(selfControlled), .setDone(pl[0]),
		.xStored(pl[1]), .yStored(pl[2]), .z1Stored(pl[3]),
		.xReadDone(pl[4]), .yReadDone(pl[5]), .z1ReadDone(pl[6]),
		.otherPending(otherPending), .stopCmd(pl[7]),
		.sampleStart(sampleStart), .filterMedian(filterMedian),
		.scanRepeat(scanRepeat), .touchReadyPinN(touchReadyPinN));
	host_model i_host (.clk_sys(clk_sys), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata));

	// --------------------------------------------
	// helpers
	// --------------------------------------------
	task automatic wrap_up();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] g, e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic pulse(input logic [7:0] m);
		@(posedge clk_sys);
		pl <= m;
		@(posedge clk_sys);
		pl <= 8'h00;
	endtask
	task automatic rs(input logic [15:0] e);
		i_host.rd(STATUS_ADDR, v);
		chk("status", v, e);
	endtask
	// pin lags the pen by the synchroniser, so wait a bounded span
	task automatic wt(input string n, input int i, input logic e);
		int k;
		k = 0;
		while (k < 12 && ob[i] !== e) begin
			@(posedge clk_sys);
			#1 k++;
		end
		chk(n, {15'h0000, ob[i]}, {15'h0000, e});
	endtask
	task automatic t_settle();
		// zero settle code pulses on the edge that sees the rise
		int e[8] = '{0, 4, 8, 12, 16, 20, 40, 40};
		int k;
		for (int c = 0; c < 8; c++) begin
			i_host.wr(CTRL_ADDR, 16'(c << 1));
			@(posedge clk_sys);
			driversOn <= 1'b1;
			k = 0;
			do begin
				@(posedge clk_sys);
				#1 k++;
			end while (sampleStart !== 1'b1 && k < 60);
			chk("settle", 16'(k), 16'(e[c] + 1));
			@(posedge clk_sys);
			driversOn <= 1'b0;
		end
	endtask

	initial begin
		#200000;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rs(16'h8000);
		i_host.rd(CTRL_ADDR, v);
		chk("control", v, CTRL_RESET);
		i_host.rd(7'h05, v);
		chk("unmapped", v, 16'h0000);
		@(posedge clk_sys) ce <= 1'b0;
		i_host.wr(CTRL_ADDR, 16'h0001);
		ce <= 1'b1;
		i_host.rd(CTRL_ADDR, v);
		chk("frozen", v, CTRL_RESET);
		i_host.wr(CTRL_ADDR, 16'h0001);
		i_host.rd(CTRL_ADDR, v);
		chk("median", {15'h0000, filterMedian}, 16'h0001);
		t_settle();
		chk("mean", {15'h0000, filterMedian}, 16'h0000);
		pulse(8'h0F);
		rs(16'h8F00);
		pulse(8'h12);
		rs(16'h8F00);
		pulse(8'h10);
		rs(16'h8B00);
		pulse(8'h20);
		rs(16'h8900);
		@(posedge clk_sys) otherPending <= 1'b1;
		pulse(8'h40);
		rs(16'h8800);
		@(posedge clk_sys) otherPending <= 1'b0;
		pulse(8'h40);
		rs(16'h8000);
		@(posedge clk_sys) penTouch <= 1'b1;
		wt("pin", 0, 1'b0);
		@(posedge clk_sys) penTouch <= 1'b0;
		repeat (8) @(posedge clk_sys);
		wt("pin", 0, 1'b0);
		pulse(8'h01);
		wt("pin", 0, 1'b1);
		pulse(8'h10);
		i_host.wr(STATUS_ADDR, 16'h0000);
		@(posedge clk_sys) penTouch <= 1'b1;
		wt("pin", 0, 1'b0);
		@(posedge clk_sys) penTouch <= 1'b0;
		wt("pin", 0, 1'b1);
		i_host.wr(STATUS_ADDR, 16'h7F00);
		pulse(8'h01);
		wt("pin", 0, 1'b0);
		rs(16'h4800);
		pulse(8'h10);
		wt("pin", 0, 1'b1);
		@(posedge clk_sys) convActive <= 1'b0;
		@(posedge clk_sys) selfControlled <= 1'b1;
		rs(16'h7000);
		@(posedge clk_sys) convActive <= 1'b1;
		@(posedge clk_sys) penTouch <= 1'b1;
		// let the synchronised pen settle, else the scan stops at once
		repeat (6) @(posedge clk_sys);
		i_host.wr(CTRL_ADDR, 16'h0400);
		wt("scan", 1, 1'b1);
		pulse(8'h80);
		wt("scan", 1, 1'b0);
		i_host.wr(CTRL_ADDR, 16'h0800);
		wt("scan", 1, 1'b1);
		@(posedge clk_sys) penTouch <= 1'b0;
		wt("scan", 1, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
